//--- shared/t16ba_pkg.sv
`default_nettype none
package t16ba_pkg;
  // Byte locations on the 8-bit bus (low byte even, high byte odd)
  localparam logic [3:0] ADDR_CNT_L  = 4'h0;
  localparam logic [3:0] ADDR_CNT_H  = 4'h1;
  localparam logic [3:0] ADDR_CMPA_L = 4'h2;
  localparam logic [3:0] ADDR_CMPA_H = 4'h3;
  localparam logic [3:0] ADDR_CMPB_L = 4'h4;
  localparam logic [3:0] ADDR_CMPB_H = 4'h5;
  localparam logic [3:0] ADDR_CMPC_L = 4'h6;
  localparam logic [3:0] ADDR_CMPC_H = 4'h7;
  localparam logic [3:0] ADDR_CAP_L  = 4'h8;
  localparam logic [3:0] ADDR_CAP_H  = 4'h9;
  // Counter landmarks
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [15:0] CNT_MAX    = 16'hffff;
  localparam logic [15:0] TOP_8BIT   = 16'h00ff;
  localparam logic [15:0] TOP_9BIT   = 16'h01ff;
  localparam logic [15:0] TOP_10BIT  = 16'h03ff;
  localparam logic [15:0] RST_VALUE  = 16'h0000;
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  // Source of the count limit
  typedef enum logic [2:0]
  {
    T16BA_TOP_MAX  = 3'h0,
    T16BA_TOP_8    = 3'h1,
    T16BA_TOP_9    = 3'h2,
    T16BA_TOP_10   = 3'h3,
    T16BA_TOP_CMPA = 3'h4,
    T16BA_TOP_CAP  = 3'h5
  } t16ba_top_sel_t;
  // Master sequencer states
  typedef enum logic [2:0]
  {
    T16BA_IDLE  = 3'b001,
    T16BA_FIRST = 3'b010,
    T16BA_SECND = 3'b100
  } t16ba_mst_st_t;
endpackage : t16ba_pkg
`default_nettype wire

//--- shared/t16ba_bus_if.sv
`default_nettype none
interface t16ba_bus_if;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  modport dev (input addr, input wdata, input wr, input rd, output rdata);
  modport mst (output addr, output wdata, output wr, output rd, input rdata);
endinterface : t16ba_bus_if
`default_nettype wire

//--- design/t16ba_timer.sv
`default_nettype none
module t16ba_timer
(
  input  wire logic                       clk,
  input  wire logic                       arst_n,
  t16ba_bus_if.dev                        bus,
  input  wire logic                       count_en,
  input  wire logic                       count_down,
  input  wire logic                       pwm_mode,
  input  wire t16ba_pkg::t16ba_top_sel_t  top_sel,
  input  wire logic                       capture_input_pin,
  input  wire logic                       capture_rising,
  input  wire logic [2:0]                 flag_clear,
  output logic [2:0]                      compare_match_flags,
  output logic                            capture_flag,
  output logic                            at_bottom,
  output logic                            at_max,
  output logic                            at_top,
  output logic                            pwm_a_allowed
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed
  {
    logic [15:0] count_value;
    logic [15:0] compare_value_a;
    logic [15:0] cmpa_buf;
    logic [15:0] cmpb;
    logic [15:0] cmpc;
    logic [15:0] capture_value;
    logic [7:0]  hold;
    logic [7:0]  rdata;
    logic [2:0]  flags;
    logic        cap_flag;
    logic        pin_s1;
    logic        pin_s2;
    logic        pin_s3;
    logic        bottom;
    logic        maxv;
    logic        top;
    logic        pwm_a;
  } t16ba_state_t;

  t16ba_state_t st_r;
  t16ba_state_t st_nxt;
  logic [15:0]  top_val;
  logic [15:0]  wr16;
  logic         cap_edge;
  logic         cmpa_is_top;

  // ----------------------------------------------------------------
  // Limit selection
  // ----------------------------------------------------------------
  always_comb
  begin
    case (top_sel)
      t16ba_pkg::T16BA_TOP_8:    top_val = t16ba_pkg::TOP_8BIT;
      t16ba_pkg::T16BA_TOP_9:    top_val = t16ba_pkg::TOP_9BIT;
      t16ba_pkg::T16BA_TOP_10:   top_val = t16ba_pkg::TOP_10BIT;
      t16ba_pkg::T16BA_TOP_CMPA: top_val = st_r.compare_value_a;
      t16ba_pkg::T16BA_TOP_CAP:  top_val = st_r.capture_value;
      default:                   top_val = t16ba_pkg::CNT_MAX;
    endcase
  end

  assign cmpa_is_top = (top_sel == t16ba_pkg::T16BA_TOP_CMPA);
  // Full word from shared holding byte plus written low byte
  assign wr16        = {st_r.hold, bus.wdata};
  // Edge seen only on synchronised samples, never on first stage
  assign cap_edge    = capture_rising ? (st_r.pin_s2 & ~st_r.pin_s3)
                                      : (~st_r.pin_s2 & st_r.pin_s3);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt        = st_r;
    st_nxt.pin_s1 = capture_input_pin;
    st_nxt.pin_s2 = st_r.pin_s1;
    st_nxt.pin_s3 = st_r.pin_s2;

    // Counter: wrap at limit; bus write below overrides this
    if (count_en)
    begin
      if (count_down)
        st_nxt.count_value = (st_r.count_value == t16ba_pkg::CNT_BOTTOM)
                             ? top_val : st_r.count_value - 16'h0001;
      else
        st_nxt.count_value = (st_r.count_value == top_val)
                             ? t16ba_pkg::CNT_BOTTOM
                             : st_r.count_value + 16'h0001;
    end

    // In PWM mode the limit buffer moves to active register at bottom, so a
    // running limit never gets skipped past mid-period
    if (!cmpa_is_top || !pwm_mode)
      st_nxt.compare_value_a = st_r.cmpa_buf;
    else if (st_r.count_value == t16ba_pkg::CNT_BOTTOM)
      st_nxt.compare_value_a = st_r.cmpa_buf;

    // Capture only while capture register is not the limit
    if (cap_edge && top_sel != t16ba_pkg::T16BA_TOP_CAP)
    begin
      st_nxt.capture_value = st_r.count_value;
      st_nxt.cap_flag      = 1'b1;
    end
    // Capture flag is sticky: flag_clear reaches compare flags only,
    // so software must fetch capture_value before the next edge

    // Flags: clear first, then set so a same-cycle event wins
    st_nxt.flags = st_r.flags & ~flag_clear;
    if (st_r.count_value == st_r.compare_value_a)
      st_nxt.flags[0] = 1'b1;
    if (st_r.count_value == st_r.cmpb)
      st_nxt.flags[1] = 1'b1;
    if (st_r.count_value == st_r.cmpc)
      st_nxt.flags[2] = 1'b1;

    // Bus writes: high byte only fills holding register
    if (bus.wr)
    begin
      case (bus.addr)
        t16ba_pkg::ADDR_CNT_H,
        t16ba_pkg::ADDR_CMPA_H,
        t16ba_pkg::ADDR_CMPB_H,
        t16ba_pkg::ADDR_CMPC_H,
        t16ba_pkg::ADDR_CAP_H:  st_nxt.hold = bus.wdata;
        t16ba_pkg::ADDR_CNT_L:  st_nxt.count_value = wr16;
        t16ba_pkg::ADDR_CMPA_L: st_nxt.cmpa_buf = wr16;
        t16ba_pkg::ADDR_CMPB_L: st_nxt.cmpb = wr16;
        t16ba_pkg::ADDR_CMPC_L: st_nxt.cmpc = wr16;
        t16ba_pkg::ADDR_CAP_L:
          if (top_sel == t16ba_pkg::T16BA_TOP_CAP)
            st_nxt.capture_value = wr16;
        default: ;
      endcase
    end

    // Bus reads: data registered, answer one cycle after rd
    if (bus.rd)
    begin
      case (bus.addr)
        t16ba_pkg::ADDR_CNT_L:
        begin
          st_nxt.rdata = st_r.count_value[7:0];
          st_nxt.hold  = st_r.count_value[15:8];
        end
        t16ba_pkg::ADDR_CAP_L:
        begin
          st_nxt.rdata = st_r.capture_value[7:0];
          st_nxt.hold  = st_r.capture_value[15:8];
        end
        t16ba_pkg::ADDR_CNT_H,
        t16ba_pkg::ADDR_CAP_H:  st_nxt.rdata = st_r.hold;
        t16ba_pkg::ADDR_CMPA_L: st_nxt.rdata = st_r.cmpa_buf[7:0];
        t16ba_pkg::ADDR_CMPA_H: st_nxt.rdata = st_r.cmpa_buf[15:8];
        t16ba_pkg::ADDR_CMPB_L: st_nxt.rdata = st_r.cmpb[7:0];
        t16ba_pkg::ADDR_CMPB_H: st_nxt.rdata = st_r.cmpb[15:8];
        t16ba_pkg::ADDR_CMPC_L: st_nxt.rdata = st_r.cmpc[7:0];
        t16ba_pkg::ADDR_CMPC_H: st_nxt.rdata = st_r.cmpc[15:8];
        default:                st_nxt.rdata = t16ba_pkg::RST_BYTE;
      endcase
    end

    // Landmarks of the new count
    st_nxt.bottom = (st_nxt.count_value == t16ba_pkg::CNT_BOTTOM);
    st_nxt.maxv   = (st_nxt.count_value == t16ba_pkg::CNT_MAX);
    st_nxt.top    = (st_nxt.count_value == top_val);
    st_nxt.pwm_a  = !(pwm_mode && cmpa_is_top);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_r        <= '0;
      st_r.bottom <= 1'b1;
      st_r.pwm_a  <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  assign bus.rdata           = st_r.rdata;
  assign compare_match_flags = st_r.flags;
  assign capture_flag        = st_r.cap_flag;
  assign at_bottom           = st_r.bottom;
  assign at_max              = st_r.maxv;
  assign at_top              = st_r.top;
  assign pwm_a_allowed       = st_r.pwm_a;
endmodule : t16ba_timer
`default_nettype wire

//--- design/t16ba_master.sv
`default_nettype none
// Bus side: turns one 16-bit request into the ordered byte pair.
// Writes go high then low, reads low then high; a request is held
// off while a pair is in flight, so no other access splits it.
module t16ba_master
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  t16ba_bus_if.mst         bus,
  input  wire logic        req,
  input  wire logic        req_wr,
  input  wire logic [2:0]  req_reg,
  input  wire logic [15:0] req_wdata,
  output logic             busy,
  output logic             done,
  output logic [15:0]      rdata
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed
  {
    t16ba_pkg::t16ba_mst_st_t fsm;
    logic                     wr;
    logic [3:0]               lo_addr;
    logic [15:0]              wdata;
    logic [15:0]              rdata;
    logic [3:0]               addr;
    logic [7:0]               bwdata;
    logic                     bwr;
    logic                     brd;
    logic                     busy;
    logic                     done;
  } t16ba_mstate_t;

  t16ba_mstate_t m_r;
  t16ba_mstate_t m_nxt;

  always_comb
  begin
    m_nxt      = m_r;
    m_nxt.bwr  = 1'b0;
    m_nxt.brd  = 1'b0;
    m_nxt.done = 1'b0;
    case (m_r.fsm)
      t16ba_pkg::T16BA_IDLE:
        if (req && !m_r.busy)
        begin
          m_nxt.wr      = req_wr;
          m_nxt.lo_addr = {req_reg, 1'b0};
          m_nxt.wdata   = req_wdata;
          m_nxt.busy    = 1'b1;
          m_nxt.fsm     = t16ba_pkg::T16BA_FIRST;
          // First byte: high on write, low on read. The high byte is
          // resent for every word, so no stale holding byte is reused
          m_nxt.addr    = {req_reg, req_wr};
          m_nxt.bwdata  = req_wdata[15:8];
          m_nxt.bwr     = req_wr;
          m_nxt.brd     = ~req_wr;
        end
      t16ba_pkg::T16BA_FIRST:
      begin
        m_nxt.fsm    = t16ba_pkg::T16BA_SECND;
        m_nxt.addr   = m_r.lo_addr | {3'h0, ~m_r.wr};
        m_nxt.bwdata = m_r.wdata[7:0];
        m_nxt.bwr    = m_r.wr;
        m_nxt.brd    = ~m_r.wr;
      end
      t16ba_pkg::T16BA_SECND:
      begin
        // Low byte arrives after first read, high after second
        if (!m_r.wr)
          m_nxt.rdata[7:0] = bus.rdata;
        m_nxt.fsm  = t16ba_pkg::T16BA_IDLE;
        m_nxt.done = m_r.wr;
        m_nxt.busy = ~m_r.wr;
      end
      default: m_nxt.fsm = t16ba_pkg::T16BA_IDLE;
    endcase
    // Read tail: capture high byte the cycle after leaving SECND
    if (m_r.fsm == t16ba_pkg::T16BA_IDLE && m_r.busy)
    begin
      m_nxt.rdata[15:8] = bus.rdata;
      m_nxt.busy        = 1'b0;
      m_nxt.done        = 1'b1;
      m_nxt.fsm         = t16ba_pkg::T16BA_IDLE;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      m_r     <= '0;
      m_r.fsm <= t16ba_pkg::T16BA_IDLE;
    end
    else
      m_r <= m_nxt;
  end

  assign bus.addr  = m_r.addr;
  assign bus.wdata = m_r.bwdata;
  assign bus.wr    = m_r.bwr;
  assign bus.rd    = m_r.brd;
  assign busy      = m_r.busy;
  assign done      = m_r.done;
  assign rdata     = m_r.rdata;
endmodule : t16ba_master
`default_nettype wire

//--- test/t16ba_chk.sv
`default_nettype none
// ----------------------------------------
// Byte order checks on the internal bus
// ----------------------------------------
module t16ba_chk
(
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // One direction per cycle keeps the holding byte meaningful
  chk_wr_rd_excl: assert property (!(wr && rd))
    else $error("read and write in one cycle");
  // High byte write is followed at once by the same word's low byte
  chk_write_hi_lo: assert property (wr && addr[0] |=>
    wr && !addr[0] && addr[3:1] == $past(addr[3:1]))
    else $error("high write not followed by low write");
  chk_low_wr_order: assert property (wr && !addr[0] |->
    $past(wr) && $past(addr[0]))
    else $error("low write without high write before it");
  // Low byte read is followed at once by the same word's high byte
  chk_read_lo_hi: assert property (rd && !addr[0] |=>
    rd && addr[0] && addr[3:1] == $past(addr[3:1]))
    else $error("low read not followed by high read");
  chk_hi_rd_order: assert property (rd && addr[0] |->
    $past(rd) && !$past(addr[0]))
    else $error("high read without low read before it");
  // Nothing outside the ten byte locations is touched
  chk_addr_mapped: assert property ((wr || rd) |-> addr <= 4'h9)
    else $error("access to unmapped byte location");
  // A finished pair is never glued to the next access
  chk_pair_gap: assert property ((wr && !addr[0]) || (rd && addr[0])
    |=> !wr && !rd)
    else $error("no idle cycle after a byte pair");
  // Read data only moves after a read strobe
  chk_rdata_hold: assert property (!rd |=> $stable(rdata))
    else $error("read data changed without a read");
endmodule : t16ba_chk
`default_nettype wire

//--- test/t16ba_tb_top.sv
`default_nettype none
// ----------------------------------------
// Timer with its byte-pair bus master
// ----------------------------------------
module t16ba_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, arst_n, req, req_wr, busy, done;
  logic        count_en, count_down, pwm_mode, pin, rise;
  logic        cap_flag, at_bottom, at_max, at_top, pwm_ok;
  logic [2:0]  req_reg, flag_clear, flags;
  logic [15:0] req_wdata, rdata, q;
  int          num_errors, n_compared, cyc;
  t16ba_pkg::t16ba_top_sel_t top_sel;
  t16ba_pkg::t16ba_top_sel_t sels[6] = '{t16ba_pkg::T16BA_TOP_MAX,
    t16ba_pkg::T16BA_TOP_8, t16ba_pkg::T16BA_TOP_9,
    t16ba_pkg::T16BA_TOP_10, t16ba_pkg::T16BA_TOP_CMPA,
    t16ba_pkg::T16BA_TOP_CAP};
  logic [15:0] tops[6] = '{16'hffff, 16'h00ff, 16'h01ff, 16'h03ff,
    16'h0040, 16'h5aa5};
  t16ba_bus_if bus_i();
  t16ba_timer t16ba_timer_inst (.clk(clk), .arst_n(arst_n), .bus(bus_i),
    .count_en(count_en), .count_down(count_down), .pwm_mode(pwm_mode),
    .top_sel(top_sel), .capture_input_pin(pin), .capture_rising(rise),
    .flag_clear(flag_clear), .compare_match_flags(flags),
    .capture_flag(cap_flag), .at_bottom(at_bottom), .at_max(at_max),
    .at_top(at_top), .pwm_a_allowed(pwm_ok));
  t16ba_master t16ba_master_inst (.clk(clk), .arst_n(arst_n),
    .bus(bus_i), .req(req), .req_wr(req_wr), .req_reg(req_reg),
    .req_wdata(req_wdata), .busy(busy), .done(done), .rdata(rdata));
  t16ba_chk t16ba_chk_inst (.clk(clk), .arst_n(arst_n),
    .addr(bus_i.addr), .wdata(bus_i.wdata), .wr(bus_i.wr),
    .rd(bus_i.rd), .rdata(bus_i.rdata));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Cycle ceiling well above the few hundred cycles the tests need
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      $display("[ERR] %0t timeout", $time);
      conclude();
    end
  end
  task automatic conclude();
    if (num_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // One word through the master; waits for its done pulse
  task automatic acc(input logic w, input logic [2:0] r,
                     input logic [15:0] d);
    int i;
    while (busy === 1'b1) tick(1);
    req_wr = w;
    req_reg = r;
    req_wdata = d;
    req = 1'b1;
    tick(1);
    req = 1'b0;
    chk({15'h0000, busy}, 16'h0001);
    for (i = 0; i < 10 && done !== 1'b1; i++) tick(1);
    chk({15'h0000, done}, 16'h0001);
    q = rdata;
  endtask : acc
  task automatic t_words();
    for (int r = 0; r < 4; r++) acc(1'b1, 3'(r), 16'h1a20 + 16'(r));
    for (int r = 0; r < 4; r++)
    begin
      acc(1'b0, 3'(r), 16'h0000);
      chk(q, 16'h1a20 + 16'(r));
    end
  endtask : t_words
  task automatic t_cap_write();
    acc(1'b1, 3'h4, 16'h5aa5);
    acc(1'b0, 3'h4, 16'h0000);
    chk(q, 16'h0000);
    top_sel = t16ba_pkg::T16BA_TOP_CAP;
    acc(1'b1, 3'h4, 16'h5aa5);
    acc(1'b0, 3'h4, 16'h0000);
    chk(q, 16'h5aa5);
  endtask : t_cap_write
  // Every limit source, with the channel A PWM veto alongside
  task automatic t_tops();
    acc(1'b1, 3'h1, 16'h0040);
    pwm_mode = 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      top_sel = sels[i];
      acc(1'b1, 3'h0, tops[i]);
      tick(2);
      chk({15'h0000, at_top}, 16'h0001);
      chk({15'h0000, at_max}, 16'(tops[i] == 16'hffff));
      chk({15'h0000, pwm_ok}, 16'(i != 4));
      acc(1'b1, 3'h0, tops[i] - 16'h0001);
      tick(2);
      chk({15'h0000, at_top}, 16'h0000);
    end
    pwm_mode = 1'b0;
    top_sel = t16ba_pkg::T16BA_TOP_MAX;
    acc(1'b1, 3'h0, 16'h0000);
    tick(2);
    chk({14'h0000, at_bottom, at_max}, 16'h0002);
  endtask : t_tops
  task automatic t_match();
    for (int r = 1; r < 4; r++) acc(1'b1, 3'(r), 16'(4 * r + 1));
    flag_clear = 3'h7;
    tick(1);
    flag_clear = 3'h0;
    chk({13'h0000, flags}, 16'h0000);
    count_en = 1'b1;
    tick(30);
    chk({13'h0000, flags}, 16'h0007);
    acc(1'b1, 3'h0, 16'h2000);
    count_en = 1'b0;
    acc(1'b0, 3'h0, 16'h0000);
    chk(16'(q >= 16'h2000 && q < 16'h2008), 16'h0001);
  endtask : t_match
  task automatic t_capture();
    acc(1'b1, 3'h0, 16'h0123);
    pin = 1'b1;
    tick(8);
    chk({15'h0000, cap_flag}, 16'h0001);
    acc(1'b0, 3'h4, 16'h0000);
    chk(q, 16'h0123);
    rise = 1'b0;
    acc(1'b1, 3'h0, 16'h0456);
    pin = 1'b0;
    tick(8);
    acc(1'b0, 3'h4, 16'h0000);
    chk(q, 16'h0456);
  endtask : t_capture
  // Down count wraps from bottom to the fixed 8-bit limit
  task automatic t_down();
    top_sel = t16ba_pkg::T16BA_TOP_8;
    acc(1'b1, 3'h0, 16'h0002);
    count_down = 1'b1;
    count_en = 1'b1;
    tick(3);
    count_en = 1'b0;
    chk({14'h0000, at_top, at_bottom}, 16'h0002);
    acc(1'b0, 3'h0, 16'h0000);
    chk(q, 16'h00ff);
    count_down = 1'b0;
    top_sel = t16ba_pkg::T16BA_TOP_MAX;
  endtask : t_down
  // Limit from compare A moves up from its buffer only at bottom
  task automatic t_buffer();
    top_sel = t16ba_pkg::T16BA_TOP_CMPA;
    pwm_mode = 1'b1;
    acc(1'b1, 3'h1, 16'h0030);
    acc(1'b1, 3'h0, 16'h0030);
    tick(2);
    chk({15'h0000, at_top}, 16'h0000);
    acc(1'b1, 3'h0, 16'h0000);
    acc(1'b1, 3'h0, 16'h0030);
    tick(2);
    chk({15'h0000, at_top}, 16'h0001);
    pwm_mode = 1'b0;
    top_sel = t16ba_pkg::T16BA_TOP_MAX;
  endtask : t_buffer
  initial
  begin
    {arst_n, req, req_wr, count_en, count_down, pwm_mode, pin} = '0;
    {req_reg, flag_clear, req_wdata, num_errors, n_compared, cyc} = '0;
    rise = 1'b1;
    top_sel = t16ba_pkg::T16BA_TOP_MAX;
    tick(12);
    arst_n = 1'b1;
    chk({13'h0000, at_bottom, at_max, pwm_ok}, 16'h0005);
    t_words();
    t_cap_write();
    t_tops();
    t_match();
    t_capture();
    t_down();
    t_buffer();
    conclude();
  end
endmodule : t16ba_tb_top
`default_nettype wire
